// [sseac_cmd.sv]
// Serial EEPROM access command interpreter behind the slave SMBus port.
// Assumes byte-level slave and master protocol engines outside this block.
`timescale 1ns/1ps
`include "sseac_consts.svh"
//
// Contract
// - First byte after slave address is the command code, captured here but never decoded.
// - Count byte appears only in block transactions; otherwise skipped.
// - Block read reply count equals bytes following it, status included.
// - Position 3 holds left-justified 7-bit EEPROM bus address, bit 0 zero.
// - Positions 4 and 5 form the 16-bit EEPROM byte address.
// - Position 6 is write data, or read data returned to host.
// - Command bit 0: zero writes, one reads.
// - Command bit 1 selects given bus address over configured one.
// - Command bit 3 flags unexpected NACK, cleared on read.
// - Command bit 4 flags 16 consecutive lost arbitrations, cleared on read.
// - Command bit 5 flags misplaced START or STOP, cleared on read.
// - Error flags mirror the SMBus status register flags.
// - Command bits 7:6 and 2 are reserved, return zero.
module sseac_cmd #(
  parameter logic [4:0] ARB_LIMIT = `SSEAC_ARB_LIMIT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Slave port byte stream
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic block_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic tx_req_i,
  // Configuration
  input wire logic [6:0] eeprom_interface_config_i,
  // Master port
  input wire logic mst_done_i,
  input wire logic [7:0] mst_rdata_i,
  input wire logic mst_nack_i,
  input wire logic mst_arb_lost_i,
  input wire logic mst_misplaced_i,
  // Slave replies
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  // Master request
  output logic mst_start_o,
  output sseac_pkg::sseac_req_t mst_req_o,
  output logic busy_o
);
  // One-hot phases: idle, receiving a frame, master access in flight
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RX = 3'b010,
    S_MST = 3'b100
  } sseac_state_t;

  sseac_state_t state_ff, nxt_state;
  logic [2:0] pos_ff, nxt_pos;
  logic [7:0] code_ff, nxt_code;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [6:0] busaddr_ff, nxt_busaddr;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] data_ff, nxt_data;
  logic [2:0] txpos_ff, nxt_txpos;
  logic [7:0] tx_byte_ff, nxt_tx_byte;
  logic tx_valid_ff, nxt_tx_valid;
  logic start_ff, nxt_start;
  sseac_pkg::sseac_req_t req_ff, nxt_req;
  logic [4:0] arb_cnt_ff, nxt_arb_cnt;
  logic [2:0] flags;
  logic rd_clr;
  sseac_pkg::sseac_err_t err_set;
  logic launch;

  // Position of a byte once the count byte is accounted for
  function automatic logic [2:0] sseac_next_pos(input logic [2:0] p, input logic blk);
    if (p == `SSEAC_POS_CODE && !blk) begin
      sseac_next_pos = `SSEAC_POS_CMD;
    end else begin
      sseac_next_pos = p + 3'h1;
    end
  endfunction

  // Arbitration losses counted in a row; only completion or the flagged loss resets it
  always_comb begin
    nxt_arb_cnt = arb_cnt_ff;
    err_set.arb_lost = 1'b0;
    if (state_ff == S_MST && mst_arb_lost_i) begin
      if (arb_cnt_ff == ARB_LIMIT - 5'h1) begin
        err_set.arb_lost = 1'b1;
        nxt_arb_cnt = 5'h0;
      end else begin
        nxt_arb_cnt = arb_cnt_ff + 5'h1;
      end
    end else if (mst_done_i) begin
      nxt_arb_cnt = 5'h0;
    end
    err_set.nack = (state_ff == S_MST) & mst_nack_i;
    err_set.misplaced = (state_ff == S_MST) & mst_misplaced_i;
  end

  // Flags outlive the access so the host can read them afterwards
  sseac_err_flags u_flags (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(err_set),
    .rd_clr_i(rd_clr),
    .flags_o(flags)
  );

  // Command byte as returned: reserved bits forced low
  logic [7:0] cmd_ret;
  always_comb begin
    cmd_ret = cmd_ff & ~`SSEAC_CMD_RSVD_MASK;
    cmd_ret[`SSEAC_BIT_NACK] = flags[0];
    cmd_ret[`SSEAC_BIT_ARB] = flags[1];
    cmd_ret[`SSEAC_BIT_COND] = flags[2];
  end

  // Frame long enough to launch: through the high address byte at least
  function automatic logic sseac_frame_complete(input logic [2:0] p, input logic v);
    sseac_frame_complete = p >= `SSEAC_POS_DATA || (v && p == `SSEAC_POS_ADDR_HI);
  endfunction

  // Last reply position; only block replies open with the count byte
  function automatic logic [2:0] sseac_reply_last(input logic blk);
    sseac_reply_last = blk ? `SSEAC_REPLY_LAST_BLOCK : `SSEAC_REPLY_LAST_SHORT;
  endfunction

  // Reply position of the command byte, just ahead of the data byte
  function automatic logic sseac_reply_is_cmd(input logic [2:0] p, input logic blk);
    sseac_reply_is_cmd = p == sseac_reply_last(blk) - 3'h1;
  endfunction

  // Reply position of the count byte, present in block replies only
  function automatic logic sseac_reply_is_count(input logic [2:0] p, input logic blk);
    sseac_reply_is_count = blk && p == 3'h0;
  endfunction

  // Frame sequencing: byte position and access phase
  always_comb begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    launch = 1'b0;
    unique case (state_ff)
      S_IDLE: begin
        if (frame_start_i) begin
          nxt_state = S_RX;
          nxt_pos = `SSEAC_POS_CODE;
        end
      end
      S_RX: begin
        // Position parks past the data byte, so extra bytes are ignored
        if (rx_valid_i && pos_ff != `SSEAC_POS_PAST) begin
          nxt_pos = sseac_next_pos(pos_ff, block_i);
        end
        // Write, or a read setup ending after the byte address
        if (frame_end_i) begin
          if (sseac_frame_complete(pos_ff, rx_valid_i)) begin
            nxt_state = S_MST;
            launch = 1'b1;
          end else begin
            nxt_state = S_IDLE;
          end
        end
      end
      S_MST: begin
        if (mst_done_i) begin
          nxt_state = S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= S_IDLE;
      pos_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
    end
  end

  // Field capture; a read result lands in the data field
  always_comb begin
    nxt_code = code_ff;
    nxt_cmd = cmd_ff;
    nxt_busaddr = busaddr_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    if (state_ff == S_RX && rx_valid_i) begin
      unique case (pos_ff)
        `SSEAC_POS_CODE: nxt_code = rx_byte_i;
        `SSEAC_POS_COUNT: ; // Length is host's to get right
        `SSEAC_POS_CMD: nxt_cmd = rx_byte_i & ~`SSEAC_CMD_RSVD_MASK;
        `SSEAC_POS_BUSADDR: nxt_busaddr = rx_byte_i[7:1];
        `SSEAC_POS_ADDR_LO: nxt_addr[7:0] = rx_byte_i;
        `SSEAC_POS_ADDR_HI: nxt_addr[15:8] = rx_byte_i;
        `SSEAC_POS_DATA: nxt_data = rx_byte_i;
        default: ;
      endcase
    end else if (state_ff == S_MST && mst_done_i && req_ff.rd) begin
      nxt_data = mst_rdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_ff <= 8'h00;
      cmd_ff <= 8'h00;
      busaddr_ff <= 7'h00;
      addr_ff <= 16'h0000;
      data_ff <= 8'h00;
    end else begin
      code_ff <= nxt_code;
      cmd_ff <= nxt_cmd;
      busaddr_ff <= nxt_busaddr;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
    end
  end

  // Request fields frozen at launch; they stand until the next command
  always_comb begin
    nxt_start = launch;
    nxt_req = req_ff;
    if (launch) begin
      nxt_req.rd = nxt_cmd[`SSEAC_BIT_RW];
      nxt_req.bus_addr = nxt_cmd[`SSEAC_BIT_GIVEN] ? nxt_busaddr
                                                   : eeprom_interface_config_i;
      nxt_req.byte_addr = nxt_addr;
      nxt_req.wdata = nxt_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_ff <= 1'b0;
      req_ff <= '0;
    end else begin
      start_ff <= nxt_start;
      req_ff <= nxt_req;
    end
  end

  // Reply bytes are served in any phase: a read frame has no start strobe
  // Limitation: data fetched while a read is in flight is the old byte
  always_comb begin
    nxt_txpos = txpos_ff;
    nxt_tx_byte = tx_byte_ff;
    nxt_tx_valid = 1'b0;
    rd_clr = 1'b0;
    if (tx_req_i) begin
      nxt_tx_valid = 1'b1;
      if (txpos_ff >= sseac_reply_last(block_i)) begin
        nxt_txpos = 3'h0;
      end else begin
        nxt_txpos = txpos_ff + 3'h1;
      end
      if (sseac_reply_is_count(txpos_ff, block_i)) begin
        nxt_tx_byte = `SSEAC_READ_COUNT;
      end else if (sseac_reply_is_cmd(txpos_ff, block_i)) begin
        nxt_tx_byte = cmd_ret;
        rd_clr = 1'b1;
      end else begin
        nxt_tx_byte = data_ff;
      end
    end else if (frame_start_i) begin
      nxt_txpos = 3'h0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txpos_ff <= 3'h0;
      tx_byte_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
    end else begin
      txpos_ff <= nxt_txpos;
      tx_byte_ff <= nxt_tx_byte;
      tx_valid_ff <= nxt_tx_valid;
    end
  end

  // Loss count spans the idle cycles between attempts of one access
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arb_cnt_ff <= 5'h0;
    end else begin
      arb_cnt_ff <= nxt_arb_cnt;
    end
  end

  // Busy is a decode of one-hot state bit, itself a flop
  assign tx_byte_o = tx_byte_ff;
  assign tx_valid_o = tx_valid_ff;
  assign mst_start_o = start_ff;
  assign mst_req_o = req_ff;
  assign busy_o = state_ff[2];
endmodule

// [sseac_consts.svh]
// Constants for the slave-port serial EEPROM command interpreter.
// Assumes inclusion by bare name from the modules.
`ifndef SSEAC_CONSTS_SVH
`define SSEAC_CONSTS_SVH
`define SSEAC_POS_CODE 3'h0
`define SSEAC_POS_COUNT 3'h1
`define SSEAC_POS_CMD 3'h2
`define SSEAC_POS_BUSADDR 3'h3
`define SSEAC_POS_ADDR_LO 3'h4
`define SSEAC_POS_ADDR_HI 3'h5
`define SSEAC_POS_DATA 3'h6
`define SSEAC_POS_PAST 3'h7
`define SSEAC_BIT_RW 0
`define SSEAC_BIT_GIVEN 1
`define SSEAC_BIT_NACK 3
`define SSEAC_BIT_ARB 4
`define SSEAC_BIT_COND 5
`define SSEAC_CMD_RSVD_MASK 8'hc4
`define SSEAC_ARB_LIMIT 5'h10
`define SSEAC_READ_COUNT 8'h02
`define SSEAC_REPLY_LAST_BLOCK 3'h2
`define SSEAC_REPLY_LAST_SHORT 3'h1
`endif

// [sseac_pkg.sv]
// Types for the slave-port serial EEPROM command interpreter.
// Assumes sseac_consts.svh is on the include path.
package sseac_pkg;
  typedef struct packed {
    logic [6:0] bus_addr;
    logic [15:0] byte_addr;
    logic [7:0] wdata;
    logic rd;
  } sseac_req_t;
  typedef struct packed {
    logic nack;
    logic arb_lost;
    logic misplaced;
  } sseac_err_t;
endpackage

// [sseac_err_flags.sv]
// Read-to-clear error flags of the EEPROM command byte.
// Assumes master-side event pulses synchronous to ref_clk_i.
`timescale 1ns/1ps
`include "sseac_consts.svh"
module sseac_err_flags (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Events and clear
  input wire sseac_pkg::sseac_err_t set_i,
  input wire logic rd_clr_i,
  // Flags
  output logic [2:0] flags_o
);
  logic [2:0] flags_ff;
  logic [2:0] nxt_flags;
  genvar g;
  // Set wins over a clear in the same cycle
  generate
    for (g = 0; g < 3; g++) begin : g_flag
      always_comb begin
        nxt_flags[g] = (flags_ff[g] & ~rd_clr_i) | set_i[2-g];
      end
    end
  endgenerate
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_ff <= 3'h0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
  assign flags_o = flags_ff;
endmodule

// [sseac_cmd_properties.sv]
// Port-level checks for the EEPROM command interpreter.
// Assumes binding to sseac_cmd; one clock domain.
`timescale 1ns/1ps
module sseac_cmd_properties #(
  parameter logic [4:0] ARB_LIMIT = 5'h10
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Observed inputs
  input wire logic frame_end_i,
  input wire logic tx_req_i,
  input wire logic mst_done_i,
  // Observed outputs
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_valid_o,
  input wire logic mst_start_o,
  input wire sseac_pkg::sseac_req_t mst_req_o,
  input wire logic busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reply_latency: assert property (tx_req_i |=> tx_valid_o)
    else $error("reply byte late");
  a_reply_cause: assert property (tx_valid_o |-> $past(tx_req_i))
    else $error("reply byte unasked");
  a_reply_stands: assert property (!$past(tx_req_i) |-> $stable(tx_byte_o))
    else $error("reply byte moved");
  a_start_cause: assert property (mst_start_o |-> $past(frame_end_i))
    else $error("start without frame end");
  a_start_busy: assert property (mst_start_o |-> busy_o && !$past(busy_o))
    else $error("start while busy");
  a_start_pulse: assert property (mst_start_o |=> !mst_start_o)
    else $error("start too long");
  a_busy_release: assert property (busy_o && mst_done_i |=> !busy_o)
    else $error("busy after done");
  a_busy_holds: assert property (busy_o && !mst_done_i |=> busy_o)
    else $error("busy dropped early");
  a_req_held: assert property (busy_o && !mst_start_o |-> $stable(mst_req_o))
    else $error("request moved");
endmodule
bind sseac_cmd sseac_cmd_properties #(.ARB_LIMIT(ARB_LIMIT)) u_props (.ref_clk_i, .rst_n_i,
  .frame_end_i, .tx_req_i, .mst_done_i, .tx_byte_o, .tx_valid_o, .mst_start_o, .mst_req_o,
  .busy_o);

// [sseac_host.sv]
// Host model on the slave port: sends command frames, pulls reply bytes.
// Assumes calls start at a falling edge; drives at falling edges.
`timescale 1ns/1ps
module sseac_host #(
  parameter logic [7:0] CODE = 8'h00 // Arbitrary value
) (
  // Clock
  input wire logic ref_clk_i,
  // Byte stream to the device
  output logic frame_start_o,
  output logic frame_end_o,
  output logic block_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_req_o,
  // Replies
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i
);
  initial {frame_start_o, frame_end_o, block_o, rx_valid_o, rx_byte_o, tx_req_o} = '0;
  task automatic put(input logic [7:0] v);
    rx_valid_o = 1'b1;
    rx_byte_o = v;
    @(negedge ref_clk_i);
  endtask
  // Bytes from the command byte on; reserved command bits are the caller's
  task automatic send(input logic [7:0] b[$], input logic blk);
    block_o = blk;
    frame_start_o = 1'b1;
    @(negedge ref_clk_i);
    frame_start_o = 1'b0;
    put(CODE);
    if (blk) put(8'(b.size()));
    foreach (b[i]) put(b[i]);
    rx_valid_o = 1'b0;
    rx_byte_o = ~rx_byte_o; // Stale byte must not look valid
    frame_end_o = 1'b1;
    @(negedge ref_clk_i);
    frame_end_o = 1'b0;
  endtask
  // Reply framing follows the transaction type of the read frame
  task automatic mode(input logic blk);
    block_o = blk;
  endtask
  task automatic fetch(output logic [7:0] d);
    tx_req_o = 1'b1;
    @(negedge ref_clk_i);
    tx_req_o = 1'b0;
    d = tx_valid_i ? tx_byte_i : 8'hxx;
    @(negedge ref_clk_i);
  endtask
endmodule

// [test_smbus_slave_eeprom_access_cmd.sv]
// Testbench for the EEPROM command interpreter.
// Assumes design, checker and host model compiled first.
`timescale 1ns/1ps
module test_smbus_slave_eeprom_access_cmd;
  localparam logic [6:0] CFG = 7'h50;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic fs, fe, blk, rxv, txr, txv, mstart, busy;
  logic mdone = 1'b0, mnack = 1'b0, marb = 1'b0, mmis = 1'b0;
  logic [7:0] rxb, txb, d;
  logic [7:0] mrd = 8'h00;
  sseac_pkg::sseac_req_t req;
  int errors = 0;
  int comparisons = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  sseac_host u_host (.ref_clk_i, .frame_start_o(fs), .frame_end_o(fe), .block_o(blk),
    .rx_valid_o(rxv), .rx_byte_o(rxb), .tx_req_o(txr), .tx_valid_i(txv), .tx_byte_i(txb));
  sseac_cmd u_dut (.ref_clk_i, .rst_n_i, .frame_start_i(fs), .frame_end_i(fe), .block_i(blk),
    .rx_valid_i(rxv), .rx_byte_i(rxb), .tx_req_i(txr), .eeprom_interface_config_i(CFG),
    .mst_done_i(mdone), .mst_rdata_i(mrd), .mst_nack_i(mnack), .mst_arb_lost_i(marb),
    .mst_misplaced_i(mmis), .tx_byte_o(txb), .tx_valid_o(txv), .mst_start_o(mstart),
    .mst_req_o(req), .busy_o(busy));
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp_req(input sseac_pkg::sseac_req_t e, input sseac_pkg::sseac_req_t s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected request expected %h seen %h", e, s);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Plays the master engine; wdata is a don't-care on reads
  task automatic master(input sseac_pkg::sseac_req_t e, input logic [7:0] rd, input logic nk,
      input int arb, input logic mis);
    sseac_pkg::sseac_req_t s;
    for (int i = 0; i < 8 && mstart !== 1'b1; i++) @(negedge ref_clk_i);
    if (mstart !== 1'b1) begin
      errors++;
      stop_test();
    end
    s = req;
    if (e.rd) s.wdata = e.wdata;
    cmp_req(e, s);
    {mnack, mmis} = {nk, mis};
    @(negedge ref_clk_i);
    {mnack, mmis} = 2'b00;
    repeat (arb) begin
      marb = 1'b1;
      @(negedge ref_clk_i);
      marb = 1'b0;
      @(negedge ref_clk_i);
    end
    {mdone, mrd} = {1'b1, rd};
    @(negedge ref_clk_i);
    mdone = 1'b0;
    cmp8("busy", 8'h00, {7'h0, busy});
  endtask
  task automatic reply(input logic [7:0] ec, input logic [7:0] ed, input logic chk,
      input logic bk);
    u_host.mode(bk);
    if (bk) begin
      u_host.fetch(d);
      cmp8("count", 8'h02, d);
    end
    u_host.fetch(d);
    cmp8("command", ec, d);
    u_host.fetch(d);
    if (chk) cmp8("data", ed, d);
  endtask
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    u_host.send({8'h02, 8'h62, 8'h78, 8'h56, 8'h9c}, 1'b0);
    master({7'h31, 16'h5678, 8'h9c, 1'b0}, 8'h00, 1'b0, 15, 1'b0);
    u_host.send({8'h00, 8'ha4, 8'h34, 8'h12, 8'h5a}, 1'b1);
    master({CFG, 16'h1234, 8'h5a, 1'b0}, 8'h00, 1'b1, 0, 1'b0);
    reply(8'h08, 8'h00, 1'b0, 1'b1);
    reply(8'h00, 8'h00, 1'b0, 1'b1);
    u_host.send({8'h03, 8'h62, 8'hef, 8'hbe}, 1'b1);
    master({7'h31, 16'hbeef, 8'h00, 1'b1}, 8'hc3, 1'b0, 16, 1'b1);
    reply(8'h33, 8'hc3, 1'b1, 1'b1);
    reply(8'h03, 8'hc3, 1'b1, 1'b0);
    u_host.send({8'h00, 8'h00, 8'h00}, 1'b1);
    repeat (4) @(negedge ref_clk_i);
    cmp8("busy", 8'h00, {7'h0, busy});
    stop_test();
  end
endmodule
